// ===== rtl/dwc_pkg.sv
// Shared constants and types for the decrement and watchdog-clear unit
package dwc_pkg;

    // ****************************************
    // Instruction word layout
    // ****************************************
    localparam int          INSTR_W    = 14;
    localparam int          DATA_W     = 8;
    localparam int          FADDR_W    = 7;
    localparam int          OPC_HI     = 11;
    localparam int          OPC_LO     = 8;
    localparam int          DEST_BIT   = 7;
    localparam int          FADDR_HI   = 6;
    localparam int          FADDR_LO   = 0;
    localparam logic [13:0] CLR_WD_ENC = 14'h0064;
    localparam logic [1:0]  TOP_ZERO   = 2'h0;
    localparam logic [3:0]  OPC_DEC    = 4'h3;
    localparam logic [3:0]  OPC_DECSZ  = 4'hB;
    localparam logic        DEST_ACC   = 1'h0;
    localparam logic [7:0]  DATA_ZERO  = 8'h00;
    localparam logic [7:0]  DATA_ONE   = 8'h01;

    // ****************************************
    // APB register map
    // ****************************************
    localparam int          APB_AW     = 8;
    localparam logic [7:0]  REG_INSTR  = 8'h00;
    localparam logic [7:0]  REG_ACC    = 8'h04;
    localparam logic [7:0]  REG_STATUS = 8'h08;
    localparam logic [7:0]  REG_WDOG   = 8'h0C;
    localparam logic [7:0]  REG_FADDR  = 8'h10;
    localparam logic [7:0]  REG_FDATA  = 8'h14;
    localparam logic [7:0]  REG_CYCLES = 8'h18;

    // ****************************************
    // Status fields and reset values
    // ****************************************
    localparam int          ST_ZERO    = 2;
    localparam int          ST_PD_N    = 3;
    localparam int          ST_TO_N    = 4;
    localparam int          ST_BUSY    = 5;
    localparam int          ST_SKIP    = 6;
    localparam logic        ZERO_RST   = 1'h0;
    localparam logic        FLAG_N_RST = 1'h1;
    localparam logic        FLAG_N_SET = 1'h1;
    localparam int          WDOG_PS_LO = 8;
    localparam int          CYC_W      = 16;
    localparam int          WD_CNT_W   = 8;
    localparam int          WD_PS_W    = 8;

    typedef enum logic [1:0] {
        OP_NONE   = 2'b00,
        OP_CLR_WD = 2'b01,
        OP_DEC    = 2'b10,
        OP_DECSZ  = 2'b11
    } dwc_op_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_READ = 2'b01,
        S_EXEC = 2'b10,
        S_NOP  = 2'b11
    } dwc_state_t;

endpackage

// ===== rtl/dwc_regfile.sv
// File register memory with registered read data
`timescale 1ns/1ps
module dwc_regfile #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input  wire logic clk,   // Core clock
    dwc_rf_if.mem     rf     // Read and write port
);
    logic [DW-1:0] mem_q [2**AW];
    logic [DW-1:0] rdata_q;

    // No reset on the array: contents are undefined until written
    always_ff @(posedge clk) begin
        if (rf.we) begin
            mem_q[rf.waddr] <= rf.wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata_q <= mem_q[rf.raddr];
    end

    assign rf.rdata = rdata_q;
endmodule

// ===== rtl/dwc_rf_if.sv
// File register port between execution logic and register memory
`timescale 1ns/1ps
interface dwc_rf_if #(
    parameter int AW = 7,
    parameter int DW = 8
);
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;

    modport ctrl (output raddr, output we, output waddr, output wdata, input rdata);
    modport mem  (input raddr, input we, input waddr, input wdata, output rdata);
endinterface

// ===== rtl/dwc_top.sv
// Execution unit for watchdog clear and file decrement instructions, APB slave
//
// Function
// - Word 00_0000_0110_0100 zeroes the watchdog counter
// - Same instruction also zeroes the watchdog prescaler
// - It sets timeout and powerdown flags only
// - Opcode 0011 decrements file, updates zero flag
// - Destination bit 0 accumulator, 1 file register
// - Opcode 1011 decrements, leaves zero, timeout and powerdown flags alone
// - Opcode 1011 zero result discards prefetched word, adds NOP
`timescale 1ns/1ps
module dwc_top (
    input  wire logic                       CLK,      // Core clock, 50 MHz
    input  wire logic                       RESET_N,  // Async reset, active low
    input  wire logic                       PSEL,     // APB select
    input  wire logic                       PENABLE,  // APB enable
    input  wire logic                       PWRITE,   // APB direction
    input  wire logic [dwc_pkg::APB_AW-1:0] PADDR,    // APB byte address
    input  wire logic [31:0]                PWDATA,   // APB write data
    output logic      [31:0]                PRDATA,   // APB read data
    output logic                            PREADY,   // APB ready
    output logic                            PSLVERR   // APB error
);
    import dwc_pkg::*;

    // ****************************************
    // Decode and arithmetic helpers
    // ****************************************
    function automatic dwc_op_t decode_op(input logic [INSTR_W-1:0] w);
        dwc_op_t op;
        op = OP_NONE;
        if (w == CLR_WD_ENC) begin
            op = OP_CLR_WD;
        end else if (w[INSTR_W-1:OPC_HI+1] == TOP_ZERO) begin
            if (w[OPC_HI:OPC_LO] == OPC_DEC) begin
                op = OP_DEC;
            end else if (w[OPC_HI:OPC_LO] == OPC_DECSZ) begin
                op = OP_DECSZ;
            end
        end
        return op;
    endfunction

    function automatic logic [DATA_W-1:0] dec_byte(input logic [DATA_W-1:0] v);
        return v - DATA_ONE;
    endfunction

    function automatic logic addr_mapped(input logic [APB_AW-1:0] a);
        return a == REG_INSTR || a == REG_ACC || a == REG_STATUS ||
               a == REG_WDOG || a == REG_FADDR || a == REG_FDATA ||
               a == REG_CYCLES;
    endfunction

    // ****************************************
    // State
    // ****************************************
    dwc_state_t           state_q;
    logic [INSTR_W-1:0]   instr_q;
    logic [DATA_W-1:0]    acc_q;
    logic                 zero_q;
    logic                 to_n_q;
    logic                 pd_n_q;
    logic                 skip_q;
    logic [FADDR_W-1:0]   faddr_q;
    logic [CYC_W-1:0]     cycles_q;
    logic [31:0]          prdata_q;
    logic                 pready_q;
    logic                 pslverr_q;

    logic                 acc_phase;
    logic                 take;
    logic                 wr_ok;
    logic                 mapped;
    logic [31:0]          rd_val;
    dwc_op_t              op;
    logic [DATA_W-1:0]    result;
    logic                 res_zero;
    logic                 is_dec;
    logic                 to_file;
    logic                 exec;
    logic                 wd_clr;
    logic [WD_CNT_W-1:0]  wd_count;
    logic [WD_PS_W-1:0]   wd_prescale;
    logic [FADDR_W-1:0]   op_faddr;

    dwc_rf_if #(.AW(FADDR_W), .DW(DATA_W)) rf ();

    // ****************************************
    // Submodules
    // ****************************************
    dwc_regfile #(
        .AW (FADDR_W),
        .DW (DATA_W)
    ) u_regfile (
        .clk (CLK),
        .rf  (rf.mem)
    );

    dwc_watchdog #(
        .CW (WD_CNT_W),
        .PW (WD_PS_W)
    ) u_watchdog (
        .clk      (CLK),
        .rst_n    (RESET_N),
        .clr      (wd_clr),
        .count    (wd_count),
        .prescale (wd_prescale)
    );

    // ****************************************
    // Execution datapath
    // ****************************************
    assign op       = decode_op(instr_q);
    assign op_faddr = instr_q[FADDR_HI:FADDR_LO];
    assign result   = dec_byte(rf.rdata);
    assign res_zero = (result == DATA_ZERO);
    assign is_dec   = (op == OP_DEC) || (op == OP_DECSZ);
    assign to_file  = instr_q[DEST_BIT] != DEST_ACC;
    assign exec     = (state_q == S_EXEC);
    assign wd_clr   = exec && (op == OP_CLR_WD);

    // ****************************************
    // APB access qualification
    // ****************************************
    // Accesses wait while an instruction runs, so no APB write races the core
    assign acc_phase = PSEL && PENABLE && !pready_q;
    assign take      = acc_phase && (state_q == S_IDLE);
    assign mapped    = addr_mapped(PADDR);
    assign wr_ok     = take && PWRITE && mapped;

    // ****************************************
    // File register port
    // ****************************************
    // Idle: the port watches the software address so FDATA reads are ready
    always_comb begin
        rf.raddr = (state_q == S_IDLE) ? faddr_q : op_faddr;
        rf.we    = 1'b0;
        rf.waddr = faddr_q;
        rf.wdata = PWDATA[DATA_W-1:0];
        if (exec && is_dec && to_file) begin
            rf.we    = 1'b1;
            rf.waddr = op_faddr;
            rf.wdata = result;
        end else if (wr_ok && PADDR == REG_FDATA) begin
            rf.we    = 1'b1;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= S_IDLE;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (wr_ok && PADDR == REG_INSTR) begin
                        state_q <= S_READ;
                    end
                end
                S_READ: begin
                    state_q <= S_EXEC;
                end
                S_EXEC: begin
                    if (op == OP_DECSZ && res_zero) begin
                        state_q <= S_NOP;
                    end else begin
                        state_q <= S_IDLE;
                    end
                end
                S_NOP: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            instr_q <= '0;
        end else if (wr_ok && PADDR == REG_INSTR && state_q == S_IDLE) begin
            instr_q <= PWDATA[INSTR_W-1:0];
        end
    end

    // One count per executed cycle, so a taken skip shows as two
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cycles_q <= '0;
        end else if (exec || state_q == S_NOP) begin
            cycles_q <= cycles_q + CYC_W'(1);
        end else if (wr_ok && PADDR == REG_CYCLES) begin
            cycles_q <= PWDATA[CYC_W-1:0];
        end
    end

    // Set when the prefetched word was thrown away
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            skip_q <= 1'b0;
        end else if (exec) begin
            skip_q <= (op == OP_DECSZ) && res_zero;
        end
    end

    // ****************************************
    // Accumulator and file address
    // ****************************************
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            acc_q <= '0;
        end else if (exec && is_dec && !to_file) begin
            acc_q <= result;
        end else if (wr_ok && PADDR == REG_ACC) begin
            acc_q <= PWDATA[DATA_W-1:0];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            faddr_q <= '0;
        end else if (wr_ok && PADDR == REG_FADDR) begin
            faddr_q <= PWDATA[FADDR_W-1:0];
        end
    end

    // ****************************************
    // Status flags
    // ****************************************
    // Skip-decrement has no branch here, so it leaves the zero flag alone
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            zero_q <= ZERO_RST;
        end else if (exec && op == OP_DEC) begin
            zero_q <= res_zero;
        end else if (wr_ok && PADDR == REG_STATUS) begin
            zero_q <= PWDATA[ST_ZERO];
        end
    end

    // Software may lower these to model sleep and time-out events
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            to_n_q <= FLAG_N_RST;
            pd_n_q <= FLAG_N_RST;
        end else if (wd_clr) begin
            to_n_q <= FLAG_N_SET;
            pd_n_q <= FLAG_N_SET;
        end else if (wr_ok && PADDR == REG_STATUS) begin
            to_n_q <= PWDATA[ST_TO_N];
            pd_n_q <= PWDATA[ST_PD_N];
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        rd_val = '0;
        unique case (PADDR)
            REG_INSTR:  rd_val[INSTR_W-1:0] = instr_q;
            REG_ACC:    rd_val[DATA_W-1:0]  = acc_q;
            REG_STATUS: begin
                rd_val[ST_ZERO] = zero_q;
                rd_val[ST_PD_N] = pd_n_q;
                rd_val[ST_TO_N] = to_n_q;
                rd_val[ST_BUSY] = (state_q != S_IDLE);
                rd_val[ST_SKIP] = skip_q;
            end
            REG_WDOG: begin
                rd_val[WD_CNT_W-1:0]                   = wd_count;
                rd_val[WDOG_PS_LO+WD_PS_W-1:WDOG_PS_LO] = wd_prescale;
            end
            REG_FADDR:  rd_val[FADDR_W-1:0]  = faddr_q;
            REG_FDATA:  rd_val[DATA_W-1:0]   = rf.rdata;
            REG_CYCLES: rd_val[CYC_W-1:0]    = cycles_q;
            default:    rd_val               = '0;
        endcase
    end

    // ****************************************
    // APB response
    // ****************************************
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= take;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= take && !mapped;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prdata_q <= '0;
        end else if (take && (!PWRITE || !mapped)) begin
            // Refused access returns zero data, even for a write
            prdata_q <= rd_val;
        end
    end

    assign PRDATA  = prdata_q;
    assign PREADY  = pready_q;
    assign PSLVERR = pslverr_q;

endmodule

// ===== rtl/dwc_watchdog.sv
// Watchdog counter with its prescaler
`timescale 1ns/1ps
module dwc_watchdog #(
    parameter int CW = 8,
    parameter int PW = 8
) (
    input  wire logic          clk,       // Core clock
    input  wire logic          rst_n,     // Async reset, active low
    input  wire logic          clr,       // Clear counter and prescaler
    output logic      [CW-1:0] count,     // Watchdog counter
    output logic      [PW-1:0] prescale   // Prescaler value
);
    logic [CW-1:0] cnt_q;
    logic [PW-1:0] ps_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_q <= '0;
        end else if (clr) begin
            ps_q <= '0;
        end else begin
            ps_q <= ps_q + PW'(1);
        end
    end

    // Counter advances once per prescaler wrap; no time-out is generated from it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (clr) begin
            cnt_q <= '0;
        end else if (&ps_q) begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    assign count    = cnt_q;
    assign prescale = ps_q;
endmodule

// ===== sim/dwc_top_chk.sv
// APB port checker for the execution unit
`timescale 1ns/1ps
module dwc_top_chk (
    input wire logic                       CLK,     // Core clock
    input wire logic                       RESET_N, // Async reset, active low
    input wire logic                       PSEL,    // APB select
    input wire logic                       PENABLE, // APB enable
    input wire logic                       PWRITE,  // APB direction
    input wire logic [dwc_pkg::APB_AW-1:0] PADDR,   // APB address
    input wire logic [31:0]                PWDATA,  // APB write data
    input wire logic [31:0]                PRDATA,  // APB read data
    input wire logic                       PREADY,  // APB ready
    input wire logic                       PSLVERR  // APB error
);
    import dwc_pkg::*;
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    logic rd_ok;
    assign rd_ok = PREADY && !PWRITE && !PSLVERR;

    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready high two cycles");
    ready_cause_a: assert property (PREADY |-> $past(PSEL && PENABLE))
        else $error("ready outside access");
    err_pair_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
        else $error("error without ready or with data");
    err_map_a: assert property (PREADY && PADDR <= REG_CYCLES && PADDR[1:0] == 2'h0 |-> !PSLVERR)
        else $error("error on mapped address");
    acc_width_a: assert property (rd_ok && PADDR == REG_ACC |-> PRDATA[31:8] == 24'h0)
        else $error("accumulator upper bits set");
    stat_width_a: assert property (rd_ok && PADDR == REG_STATUS |-> PRDATA[31:7] == 25'h0)
        else $error("status upper bits set");
    wdog_width_a: assert property (rd_ok && PADDR == REG_WDOG |-> PRDATA[31:16] == 16'h0)
        else $error("watchdog upper bits set");
    instr_stall_a: assert property (PREADY && PWRITE && PADDR == REG_INSTR |=> !PREADY [*2])
        else $error("access taken during execution");
endmodule

bind dwc_top dwc_top_chk chk_u (
    .CLK     (CLK),
    .RESET_N (RESET_N),
    .PSEL    (PSEL),
    .PENABLE (PENABLE),
    .PWRITE  (PWRITE),
    .PADDR   (PADDR),
    .PWDATA  (PWDATA),
    .PRDATA  (PRDATA),
    .PREADY  (PREADY),
    .PSLVERR (PSLVERR)
);

// ===== sim/dwc_top_tb.sv
// Self-checking APB bench for the execution unit
`timescale 1ns/1ps
module dwc_top_tb;
    import dwc_pkg::*;
    logic        clk     = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    int          n_mismatch  = 0;
    int          check_count = 0;
    logic [31:0] d;
    logic        e;
    logic [13:0] w;
    logic [7:0]  v;
    logic [7:0]  res;
    logic        isdec;
    logic        pz;
    logic        skp;
    logic        ez;
    logic [13:0] words [8] = '{14'h0064, 14'h0305, 14'h03FF, 14'h0B80, 14'h0B2A, 14'h0065, 14'h0B01, 14'h0364};
    logic [7:0]  vals  [8] = '{8'h33, 8'h01, 8'h00, 8'h01, 8'h80, 8'h44, 8'h01, 8'h10};

    always #10 clk = ~clk;

    dwc_top dut_u (
        .CLK     (clk),
        .RESET_N (reset_n),
        .PSEL    (psel),
        .PENABLE (penable),
        .PWRITE  (pwrite),
        .PADDR   (paddr),
        .PWDATA  (pwdata),
        .PRDATA  (prdata),
        .PREADY  (pready),
        .PSLVERR (pslverr)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Holds the request until ready is sampled high; bounded wait
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("unexpected at %0t: no ready", $time);
            print_verdict();
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        xfer(1'b0, REG_ACC, 32'h0);
        check(d, 32'h0);
        xfer(1'b0, REG_STATUS, 32'h0);
        check(d, 32'h18);
        xfer(1'b0, REG_CYCLES, 32'h0);
        check(d, 32'h0);
        xfer(1'b0, 8'h1C, 32'h0);
        check({e, d[30:0]}, 32'h80000000);
        xfer(1'b1, 8'h40, 32'hFF);
        check({31'h0, e}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            w = words[i];
            v = vals[i];
            pz = i[0];
            res = v - 8'h01;
            isdec = w[13:12] == 2'h0 && (w[11:8] == OPC_DEC || w[11:8] == OPC_DECSZ);
            skp = isdec && w[11:8] == OPC_DECSZ && res == DATA_ZERO;
            ez = (isdec && w[11:8] == OPC_DEC) ? (res == DATA_ZERO) : pz;
            xfer(1'b1, REG_FADDR, {25'h0, w[6:0]});
            xfer(1'b1, REG_FDATA, {24'h0, v});
            xfer(1'b1, REG_ACC, 32'h5A);
            xfer(1'b1, REG_STATUS, {29'h0, pz, 2'h0});
            xfer(1'b1, REG_CYCLES, 32'h0);
            // Let the watchdog advance so a missing clear shows
            if (w == CLR_WD_ENC) repeat (600) @(posedge clk);
            xfer(1'b1, REG_INSTR, {18'h0, w});
            if (w == CLR_WD_ENC) begin
                xfer(1'b0, REG_WDOG, 32'h0);
                check({24'h0, d[7:0]}, 32'h0);
                check({31'h0, d[15:8] < 8'h20}, 32'h1);
            end
            xfer(1'b0, REG_ACC, 32'h0);
            check(d, (isdec && !w[7]) ? {24'h0, res} : 32'h5A);
            xfer(1'b0, REG_FDATA, 32'h0);
            check(d, (isdec && w[7]) ? {24'h0, res} : {24'h0, v});
            xfer(1'b0, REG_STATUS, 32'h0);
            check(d, {25'h0, skp, 1'b0, {2{w == CLR_WD_ENC}}, ez, 2'h0});
            xfer(1'b0, REG_CYCLES, 32'h0);
            check(d, {31'h0, skp} + 32'h1);
        end
        // Refused write after a non-zero read must still return zero data
        xfer(1'b1, 8'h40, 32'hFF);
        check({e, d[30:0]}, 32'h80000000);
        print_verdict();
    end
endmodule
